// file: src/spwt_map.svh
// register offsets, field positions and reset values of the stop and periodic timer block
`ifndef SPWT_MAP_SVH
`define SPWT_MAP_SVH

`define SPWT_OFF_CTRL 8'h00
`define SPWT_OFF_PERIOD 8'h04
`define SPWT_OFF_STOP 8'h08
`define SPWT_OFF_STAT 8'h0c
`define SPWT_OFF_EVT 8'h10
`define SPWT_OFF_MASK 8'h14

`define SPWT_CTRL_CLKSEL 7
`define SPWT_CTRL_WAVESEL 4
`define SPWT_CTRL_PINEN 3
`define SPWT_CTRL_FE 2
`define SPWT_CTRL_IE 1
`define SPWT_CTRL_FLAG 0

`define SPWT_STOP_PSEUDO_STOP_SELECT 0
`define SPWT_STOP_CRYSTAL_OSCILLATOR_ENABLE 1
`define SPWT_STOP_LOOPSEL 2
`define SPWT_STOP_WDSEL 3
`define SPWT_STOP_TICKSEL 4

`define SPWT_EVT_TIMEOUT 0
`define SPWT_EVT_STOPIN 1
`define SPWT_EVT_WAKE 2

`define SPWT_RST_CTRL 8'h00
`define SPWT_RST_PERIOD 16'h0000
`define SPWT_RST_STOP 5'h00
`define SPWT_RST_EVT 3'h0
`define SPWT_RST_MASK 3'h0

`endif

// file: src/spwt_pkg.sv
// types shared by the stop and periodic timer block
package spwt_pkg;
  typedef enum logic [2:0] {
    SPWT_RUN = 3'b001,
    SPWT_FULL = 3'b010,
    SPWT_PSEUDO = 3'b100
  } spwt_mode_t;
  typedef logic [7:0] spwt_addr_t;
endpackage

// file: src/spwt_tick_gen.sv
// half-step source for the periodic timer: synchronised autonomous clock or bus clock
`timescale 1ns/1ps
module spwt_tick_gen (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic autoClk,
  input wire logic useBusClk,
  input wire logic busClkRun,
  output logic halfStep
);
  import spwt_pkg::*;

  logic sync1_ff;
  logic sync2_ff;
  logic prev_ff;
  logic nxt_sync1;
  logic nxt_sync2;
  logic nxt_prev;

  always_comb begin
    nxt_sync1 = autoClk;
    nxt_sync2 = sync1_ff;
    nxt_prev = sync2_ff;
    // each edge of the slow clock is half a period step
    halfStep = useBusClk ? busClkRun : (sync2_ff ^ prev_ff);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      prev_ff <= 1'b0;
    end else begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
      prev_ff <= nxt_prev;
    end
  end
endmodule

// file: src/spwt_top.sv
// stop mode control and autonomous periodic wake-up timer with apb registers
//
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "spwt_map.svh"

module spwt_top #(
  parameter int PERIOD_W = 16
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire spwt_pkg::spwt_addr_t paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic autoClk,
  input wire logic stopInstr,
  input wire logic wakeupReq,
  input wire logic watchdogActive,
  input wire logic tickActive,
  output logic periodic_waveform_pin,
  output logic irq,
  output spwt_pkg::spwt_mode_t stopMode,
  output logic coreClkEn,
  output logic busClkEn,
  output logic debugClkEn,
  output logic loopEn,
  output logic ref1mEn,
  output logic xoscEn,
  output logic watchdogClkEn,
  output logic tickClkEn,
  output logic loop_clock_select,
  output logic watchdog_clock_select,
  output logic tick_clock_select
);
  import spwt_pkg::*;

  // apb decode
  logic wrAcc;
  logic rdSetup;
  logic hitCtrl;
  logic hitPeriod;
  logic hitStop;
  logic hitStat;
  logic hitEvt;
  logic hitMask;
  logic mapped;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;

  always_comb begin
    hitCtrl = (paddr == `SPWT_OFF_CTRL);
    hitPeriod = (paddr == `SPWT_OFF_PERIOD);
    hitStop = (paddr == `SPWT_OFF_STOP);
    hitStat = (paddr == `SPWT_OFF_STAT);
    hitEvt = (paddr == `SPWT_OFF_EVT);
    hitMask = (paddr == `SPWT_OFF_MASK);
    mapped = hitCtrl | hitPeriod | hitStop | hitStat | hitEvt | hitMask;
    // zero wait states: read data is captured in the setup cycle
    pready = 1'b1;
    pslverr = psel & penable & ~mapped;
    wrAcc = psel & penable & pwrite & mapped;
    rdSetup = psel & ~penable & ~pwrite;
  end

  // control and period register fields
  logic clkSel_ff;
  logic waveSel_ff;
  logic pinEn_ff;
  logic fe_ff;
  logic ie_ff;
  logic flag_ff;
  logic [PERIOD_W-1:0] period_ff;
  logic nxt_clkSel;
  logic nxt_waveSel;
  logic nxt_pinEn;
  logic nxt_fe;
  logic nxt_ie;
  logic nxt_flag;
  logic [PERIOD_W-1:0] nxt_period;
  logic wrCtrl;
  logic periodEnd;

  always_comb begin
    wrCtrl = wrAcc & hitCtrl & pstrb[0];
    nxt_clkSel = clkSel_ff;
    nxt_waveSel = waveSel_ff;
    nxt_pinEn = pinEn_ff;
    nxt_fe = fe_ff;
    nxt_ie = ie_ff;
    nxt_period = period_ff;
    if (wrCtrl) begin
      // a bus-clock timer would jump rate mid-period, hence the lock
      if (!fe_ff && !pwdata[`SPWT_CTRL_FE]) begin
        nxt_clkSel = pwdata[`SPWT_CTRL_CLKSEL];
      end
      nxt_waveSel = pwdata[`SPWT_CTRL_WAVESEL];
      nxt_pinEn = pwdata[`SPWT_CTRL_PINEN];
      nxt_fe = pwdata[`SPWT_CTRL_FE];
      nxt_ie = pwdata[`SPWT_CTRL_IE];
    end
    if (wrAcc && hitPeriod && pstrb[0]) begin
      nxt_period[7:0] = pwdata[7:0];
    end
    if (wrAcc && hitPeriod && pstrb[1]) begin
      nxt_period[PERIOD_W-1:8] = pwdata[PERIOD_W-1:8];
    end
    // set wins over a simultaneous write-one clear
    nxt_flag = (flag_ff & ~(wrCtrl & pwdata[`SPWT_CTRL_FLAG])) | periodEnd;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      clkSel_ff <= 1'b0;
      waveSel_ff <= 1'b0;
      pinEn_ff <= 1'b0;
      fe_ff <= 1'b0;
      ie_ff <= 1'b0;
      flag_ff <= 1'b0;
      period_ff <= `SPWT_RST_PERIOD;
    end else begin
      clkSel_ff <= nxt_clkSel;
      waveSel_ff <= nxt_waveSel;
      pinEn_ff <= nxt_pinEn;
      fe_ff <= nxt_fe;
      ie_ff <= nxt_ie;
      flag_ff <= nxt_flag;
      period_ff <= nxt_period;
    end
  end

  // stop mode state
  spwt_mode_t mode_ff;
  spwt_mode_t nxt_mode;
  logic pseudo_stop_select_ff;
  logic crystal_oscillator_enable_ff;
  logic loopSel_ff;
  logic wdSel_ff;
  logic tickSel_ff;
  logic nxt_pseudo_stop_select;
  logic nxt_crystal_oscillator_enable;
  logic nxt_loopSel;
  logic nxt_wdSel;
  logic nxt_tickSel;
  logic stopIn;
  logic wakeUp;
  logic wake;

  always_comb begin
    nxt_mode = mode_ff;
    nxt_pseudo_stop_select = pseudo_stop_select_ff;
    nxt_crystal_oscillator_enable = crystal_oscillator_enable_ff;
    nxt_loopSel = loopSel_ff;
    nxt_wdSel = wdSel_ff;
    nxt_tickSel = tickSel_ff;
    stopIn = 1'b0;
    wakeUp = 1'b0;
    wake = wakeupReq | irq;
    if (wrAcc && hitStop && pstrb[0]) begin
      nxt_pseudo_stop_select = pwdata[`SPWT_STOP_PSEUDO_STOP_SELECT];
      nxt_crystal_oscillator_enable = pwdata[`SPWT_STOP_CRYSTAL_OSCILLATOR_ENABLE];
      nxt_loopSel = pwdata[`SPWT_STOP_LOOPSEL];
      nxt_wdSel = pwdata[`SPWT_STOP_WDSEL];
      nxt_tickSel = pwdata[`SPWT_STOP_TICKSEL];
    end
    case (mode_ff)
      SPWT_RUN: begin
        if (stopInstr) begin
          stopIn = 1'b1;
          // pseudo stop needs both bits, anything else is full stop
          nxt_mode = (pseudo_stop_select_ff && crystal_oscillator_enable_ff) ? SPWT_PSEUDO : SPWT_FULL;
        end
      end
      SPWT_FULL: begin
        if (wake) begin
          wakeUp = 1'b1;
          nxt_mode = SPWT_RUN;
          nxt_loopSel = 1'b1;
          nxt_wdSel = 1'b0;
          nxt_tickSel = 1'b0;
        end
      end
      SPWT_PSEUDO: begin
        if (wake) begin
          wakeUp = 1'b1;
          nxt_mode = SPWT_RUN;
        end
      end
      default: begin
        nxt_mode = SPWT_RUN;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_ff <= SPWT_RUN;
      pseudo_stop_select_ff <= 1'b0;
      crystal_oscillator_enable_ff <= 1'b0;
      loopSel_ff <= 1'b0;
      wdSel_ff <= 1'b0;
      tickSel_ff <= 1'b0;
    end else begin
      mode_ff <= nxt_mode;
      pseudo_stop_select_ff <= nxt_pseudo_stop_select;
      crystal_oscillator_enable_ff <= nxt_crystal_oscillator_enable;
      loopSel_ff <= nxt_loopSel;
      wdSel_ff <= nxt_wdSel;
      tickSel_ff <= nxt_tickSel;
    end
  end

  // clock gating decoded from the mode register, the crystal enable bit and the activity inputs
  always_comb begin
    stopMode = mode_ff;
    coreClkEn = mode_ff[0];
    busClkEn = mode_ff[0];
    debugClkEn = mode_ff[0];
    loopEn = mode_ff[0];
    ref1mEn = mode_ff[0];
    xoscEn = crystal_oscillator_enable_ff & ~mode_ff[1];
    watchdogClkEn = mode_ff[0] | (mode_ff[2] & watchdogActive);
    tickClkEn = mode_ff[0] | (mode_ff[2] & tickActive);
    loop_clock_select = loopSel_ff;
    watchdog_clock_select = wdSel_ff;
    tick_clock_select = tickSel_ff;
  end

  // periodic timer, counted in half steps of the selected clock
  logic halfStep;
  logic [PERIOD_W:0] halfCnt_ff;
  logic [PERIOD_W:0] nxt_halfCnt;
  logic [PERIOD_W:0] lastHalf;
  logic toggle_ff;
  logic nxt_toggle;
  logic pin_ff;
  logic nxt_pin;

  // bus-clock source stops with the bus clock, autonomous one keeps going
  spwt_tick_gen u_tick (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .autoClk(autoClk),
    .useBusClk(clkSel_ff),
    .busClkRun(mode_ff[0]),
    .halfStep(halfStep)
  );

  always_comb begin
    lastHalf = {period_ff, 1'b1};
    nxt_halfCnt = halfCnt_ff;
    nxt_toggle = toggle_ff;
    periodEnd = 1'b0;
    if (!fe_ff) begin
      nxt_halfCnt = '0;
      nxt_toggle = 1'b0;
    end else if (halfStep) begin
      // >= so a shortened period still wraps
      if (halfCnt_ff >= lastHalf) begin
        nxt_halfCnt = '0;
        periodEnd = 1'b1;
        nxt_toggle = ~toggle_ff;
      end else begin
        nxt_halfCnt = halfCnt_ff + 1'b1;
      end
    end
    if (!(pinEn_ff && fe_ff)) begin
      nxt_pin = 1'b0;
    end else if (waveSel_ff) begin
      nxt_pin = toggle_ff;
    end else begin
      nxt_pin = (halfCnt_ff >= lastHalf);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      halfCnt_ff <= '0;
      toggle_ff <= 1'b0;
      pin_ff <= 1'b0;
    end else begin
      halfCnt_ff <= nxt_halfCnt;
      toggle_ff <= nxt_toggle;
      pin_ff <= nxt_pin;
    end
  end

  assign periodic_waveform_pin = pin_ff;

  // event status, mask and interrupt
  logic [2:0] evt_ff;
  logic [2:0] mask_ff;
  logic [2:0] nxt_evt;
  logic [2:0] nxt_mask;
  logic [2:0] evtSet;
  logic [2:0] evtClr;

  always_comb begin
    evtSet = '0;
    evtSet[`SPWT_EVT_TIMEOUT] = periodEnd;
    evtSet[`SPWT_EVT_STOPIN] = stopIn;
    evtSet[`SPWT_EVT_WAKE] = wakeUp;
    evtClr = (wrAcc && hitEvt && pstrb[0]) ? pwdata[2:0] : 3'h0;
    nxt_evt = (evt_ff & ~evtClr) | evtSet;
    nxt_mask = (wrAcc && hitMask && pstrb[0]) ? pwdata[2:0] : mask_ff;
    irq = (flag_ff & ie_ff) | (|(evt_ff & mask_ff));
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      evt_ff <= `SPWT_RST_EVT;
      mask_ff <= `SPWT_RST_MASK;
    end else begin
      evt_ff <= nxt_evt;
      mask_ff <= nxt_mask;
    end
  end

  // read data
  always_comb begin
    nxt_prdata = prdata_ff;
    if (rdSetup) begin
      nxt_prdata = 32'h0000_0000;
      if (hitCtrl) begin
        nxt_prdata[`SPWT_CTRL_CLKSEL] = clkSel_ff;
        nxt_prdata[`SPWT_CTRL_WAVESEL] = waveSel_ff;
        nxt_prdata[`SPWT_CTRL_PINEN] = pinEn_ff;
        nxt_prdata[`SPWT_CTRL_FE] = fe_ff;
        nxt_prdata[`SPWT_CTRL_IE] = ie_ff;
        nxt_prdata[`SPWT_CTRL_FLAG] = flag_ff;
      end else if (hitPeriod) begin
        nxt_prdata[PERIOD_W-1:0] = period_ff;
      end else if (hitStop) begin
        nxt_prdata[`SPWT_STOP_PSEUDO_STOP_SELECT] = pseudo_stop_select_ff;
        nxt_prdata[`SPWT_STOP_CRYSTAL_OSCILLATOR_ENABLE] = crystal_oscillator_enable_ff;
        nxt_prdata[`SPWT_STOP_LOOPSEL] = loopSel_ff;
        nxt_prdata[`SPWT_STOP_WDSEL] = wdSel_ff;
        nxt_prdata[`SPWT_STOP_TICKSEL] = tickSel_ff;
      end else if (hitStat) begin
        nxt_prdata[2:0] = mode_ff;
        nxt_prdata[3] = pin_ff;
        nxt_prdata[4] = toggle_ff;
      end else if (hitEvt) begin
        nxt_prdata[2:0] = evt_ff;
      end else if (hitMask) begin
        nxt_prdata[2:0] = mask_ff;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_ff <= 32'h0000_0000;
    end else begin
      prdata_ff <= nxt_prdata;
    end
  end

  assign prdata = prdata_ff;
endmodule

// file: bench/spwt_cpu_model.sv
// cpu side model: apb master, stop instruction and wake source
`timescale 1ns/1ps
module spwt_cpu_model #(
  parameter int OSC_START = 16
) (
  input wire logic sys_clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output spwt_pkg::spwt_addr_t paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic stopInstr,
  output logic wakeupReq
);
  import spwt_pkg::*;
  logic hang = 1'b0;
  initial begin
    {psel, penable, pwrite, pstrb, stopInstr, wakeupReq} = '0;
    paddr = '0;
    pwdata = '0;
  end
  // request held until pready is seen high at a rising edge
  task automatic xfer(input logic w, input spwt_addr_t a, input logic [31:0] d,
      output logic [31:0] q, output logic err);
    int t;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'hf;
    @(posedge sys_clk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge sys_clk);
      t++;
    end while (pready !== 1'b1 && t < 64);
    hang = (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge, so a following call never drives psel twice in one step
    @(posedge sys_clk);
  endtask
  // settle first: crystal may just have been switched on
  task automatic stopPulse();
    repeat (OSC_START) @(posedge sys_clk);
    stopInstr <= 1'b1;
    @(posedge sys_clk);
    stopInstr <= 1'b0;
  endtask
  task automatic wake();
    wakeupReq <= 1'b1;
    @(posedge sys_clk);
    wakeupReq <= 1'b0;
  endtask
endmodule

// file: bench/spwt_monitor.sv
// port level assertions for the stop and periodic timer block
`timescale 1ns/1ps
`include "spwt_map.svh"
module spwt_monitor (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire spwt_pkg::spwt_addr_t paddr,
  input wire logic [31:0] pwdata,
  input wire logic stopInstr,
  input wire logic watchdogActive,
  input wire logic tickActive,
  input wire logic periodic_waveform_pin,
  input wire spwt_pkg::spwt_mode_t stopMode,
  input wire logic coreClkEn,
  input wire logic busClkEn,
  input wire logic debugClkEn,
  input wire logic loopEn,
  input wire logic ref1mEn,
  input wire logic xoscEn,
  input wire logic watchdogClkEn,
  input wire logic tickClkEn,
  input wire logic loop_clock_select,
  input wire logic watchdog_clock_select,
  input wire logic tick_clock_select
);
  import spwt_pkg::*;
  logic [1:0] stopSh_ff, nxt_stopSh;
  logic gate_ff, nxt_gate;
  logic wrAcc;
  assign wrAcc = psel && penable && pwrite;
  // shadows of the bits that the checks depend on
  always_comb begin
    nxt_stopSh = stopSh_ff;
    nxt_gate = gate_ff;
    if (wrAcc && paddr == `SPWT_OFF_STOP) nxt_stopSh = pwdata[1:0];
    if (wrAcc && paddr == `SPWT_OFF_CTRL) nxt_gate = pwdata[3] && pwdata[2];
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stopSh_ff <= 2'h0;
      gate_ff <= 1'b0;
    end else begin
      stopSh_ff <= nxt_stopSh;
      gate_ff <= nxt_gate;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  chk_stop_choice: assert property (stopMode == SPWT_RUN && stopInstr |=>
    stopMode == ($past(&stopSh_ff) ? SPWT_PSEUDO : SPWT_FULL)) else $error("bad stop kind");
  chk_stay_run: assert property (stopMode == SPWT_RUN && !stopInstr |=>
    stopMode == SPWT_RUN) else $error("left run without stop");
  chk_clocks_halt: assert property (
    {coreClkEn, busClkEn, debugClkEn, loopEn, ref1mEn} == {5{stopMode == SPWT_RUN}})
    else $error("clock enables wrong");
  chk_full_xosc: assert property (stopMode == SPWT_FULL |-> !xoscEn)
    else $error("crystal on in full stop");
  chk_full_wake: assert property ($past(stopMode) == SPWT_FULL && stopMode == SPWT_RUN |->
    {loop_clock_select, watchdog_clock_select, tick_clock_select} == 3'b100)
    else $error("selects after full stop");
  chk_pseudo_run: assert property (stopMode == SPWT_PSEUDO |-> xoscEn &&
    watchdogClkEn == watchdogActive && tickClkEn == tickActive) else $error("pseudo clocks");
  chk_pseudo_sel: assert property (stopMode == SPWT_PSEUDO |=>
    $stable({loop_clock_select, watchdog_clock_select, tick_clock_select}))
    else $error("selects moved in pseudo stop");
  chk_pin_gate: assert property (!$past(gate_ff) |-> !periodic_waveform_pin)
    else $error("pin active while gated");
  cover property (stopMode == SPWT_PSEUDO);
  cover property (stopMode == SPWT_FULL);
  cover property ($rose(periodic_waveform_pin));
endmodule
bind spwt_top spwt_monitor chk (.sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
  .stopInstr, .watchdogActive, .tickActive, .periodic_waveform_pin, .stopMode, .coreClkEn,
  .busClkEn, .debugClkEn, .loopEn, .ref1mEn, .xoscEn, .watchdogClkEn, .tickClkEn,
  .loop_clock_select, .watchdog_clock_select, .tick_clock_select);

// file: bench/spwt_tb_top.sv
// self-checking bench for the stop mode and periodic timer block
`timescale 1ns/1ps
`include "spwt_map.svh"
module spwt_tb_top;
  import spwt_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic autoClk = 1'b0;
  logic watchdogActive = 1'b1;
  logic tickActive = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, stopInstr, wakeupReq, irq, err;
  logic periodic_waveform_pin, coreClkEn, busClkEn, debugClkEn, loopEn, ref1mEn, xoscEn;
  logic watchdogClkEn, tickClkEn, loop_clock_select, watchdog_clock_select, tick_clock_select;
  spwt_addr_t paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0] pstrb;
  logic [2:0] sels;
  spwt_mode_t stopMode;
  int n_errors = 0;
  int n_checks = 0;
  int seed = 32'hd1370264;
  int aCnt = 0;
  int p, hi, pseudo;
  spwt_top dut (.sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .autoClk, .stopInstr, .wakeupReq, .watchdogActive, .tickActive,
    .periodic_waveform_pin, .irq, .stopMode, .coreClkEn, .busClkEn, .debugClkEn, .loopEn,
    .ref1mEn, .xoscEn, .watchdogClkEn, .tickClkEn, .loop_clock_select, .watchdog_clock_select,
    .tick_clock_select);
  spwt_cpu_model cpu (.sys_clk, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .stopInstr, .wakeupReq);
  always #50 sys_clk = ~sys_clk;
  // slow autonomous clock, one edge every third bus cycle
  always @(posedge sys_clk) begin
    aCnt <= aCnt + 1;
    if (aCnt % 3 == 2) autoClk <= ~autoClk;
  end
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic fail();
    n_errors++;
    summarize();
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input spwt_addr_t a, input logic [31:0] d);
    cpu.xfer(w, a, d, q, err);
    if (cpu.hang) fail();
  endtask
  // cycles the pin stays high in its next high phase
  task automatic width(output int h);
    int t;
    t = 0;
    h = 0;
    while (periodic_waveform_pin !== 1'b1) begin
      @(posedge sys_clk);
      if (++t > 100) fail();
    end
    while (periodic_waveform_pin === 1'b1) begin
      @(posedge sys_clk);
      if (++h > 100) fail();
    end
  endtask
  initial begin
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    bus(0, `SPWT_OFF_CTRL, 0);
    check(q, `SPWT_RST_CTRL);
    bus(0, 8'h40, 0);
    check({31'h0, err}, 32'h1);
    bus(1, `SPWT_OFF_CTRL, 32'h84);
    bus(0, `SPWT_OFF_CTRL, 0);
    check(q & 32'hfe, 32'h04);
    bus(1, `SPWT_OFF_CTRL, 32'h00);
    bus(1, `SPWT_OFF_CTRL, 32'h80);
    bus(0, `SPWT_OFF_CTRL, 0);
    check(q & 32'hfe, 32'h80);
    for (int w = 0; w < 2; w++) begin
      p = $random(seed) & 3;
      bus(1, `SPWT_OFF_CTRL, 32'h80);
      bus(1, `SPWT_OFF_PERIOD, p);
      bus(1, `SPWT_OFF_CTRL, 32'h8c | (w << 4));
      width(hi);
      check(hi, w ? 2 * (p + 1) : 1);
      width(hi);
      check(hi, w ? 2 * (p + 1) : 1);
    end
    bus(1, `SPWT_OFF_CTRL, 32'h94);
    @(posedge sys_clk);
    hi = 0;
    repeat (20) @(posedge sys_clk) hi += (periodic_waveform_pin !== 1'b0);
    check(hi, 0);
    bus(1, `SPWT_OFF_CTRL, 32'h80);
    bus(0, `SPWT_OFF_CTRL, 0);
    check(q, 32'h81);
    check({31'h0, irq}, 0);
    bus(1, `SPWT_OFF_CTRL, 32'h81);
    bus(0, `SPWT_OFF_CTRL, 0);
    check(q, 32'h80);
    bus(1, `SPWT_OFF_CTRL, 32'h86);
    hi = 0;
    while (irq !== 1'b1) begin
      @(posedge sys_clk);
      if (++hi > 20) fail();
    end
    check(hi, 2 * p + 2);
    bus(1, `SPWT_OFF_CTRL, 32'h82);
    bus(1, `SPWT_OFF_CTRL, 32'h83);
    @(posedge sys_clk);
    check({31'h0, irq}, 0);
    bus(1, `SPWT_OFF_EVT, 32'h7);
    for (int m = 0; m < 4; m++) begin
      pseudo = (m == 3);
      tickActive <= 1'($random(seed));
      watchdogActive <= 1'($random(seed));
      bus(1, `SPWT_OFF_STOP, 32'h18 | m);
      cpu.stopPulse();
      @(posedge sys_clk);
      check({29'h0, stopMode}, pseudo ? SPWT_PSEUDO : SPWT_FULL);
      check({coreClkEn, busClkEn, debugClkEn, loopEn, ref1mEn}, 0);
      check({xoscEn, watchdogClkEn, tickClkEn}, pseudo ? {1'b1, watchdogActive, tickActive} : 0);
      cpu.wake();
      @(posedge sys_clk);
      check({29'h0, stopMode}, SPWT_RUN);
      sels = {loop_clock_select, watchdog_clock_select, tick_clock_select};
      check(sels, pseudo ? 3'b011 : 3'b100);
      check({coreClkEn, busClkEn, debugClkEn, loopEn, ref1mEn, watchdogClkEn, tickClkEn}, 7'h7f);
    end
    bus(0, `SPWT_OFF_EVT, 0);
    check(q, 32'h6);
    bus(1, `SPWT_OFF_MASK, 32'h2);
    @(posedge sys_clk);
    check(irq, 1);
    bus(1, `SPWT_OFF_MASK, 32'h0);
    @(posedge sys_clk);
    check(irq, 0);
    bus(1, `SPWT_OFF_EVT, 32'h6);
    bus(0, `SPWT_OFF_EVT, 0);
    check(q, 0);
    bus(1, `SPWT_OFF_CTRL, 32'h00);
    bus(1, `SPWT_OFF_PERIOD, 32'd9);
    bus(1, `SPWT_OFF_STOP, 32'h0);
    bus(1, `SPWT_OFF_CTRL, 32'h06);
    cpu.stopPulse();
    hi = 0;
    // only the timer interrupt can end this stop
    while (stopMode !== SPWT_RUN || hi == 0) begin
      @(posedge sys_clk);
      if (++hi > 300) fail();
    end
    bus(0, `SPWT_OFF_CTRL, 0);
    check(q, 32'h07);
    summarize();
  end
endmodule
